// ==== rtc_defs.svh ====
// Offsets, field positions, reset values and counts for the seconds RTC
//
// Functional notes
// - 32-bit seconds count, once per second
// - No calendar logic, raw seconds only
// - Time-of-day alarm from 1 s to 12 days
// - Sub-second alarm, 1/4096 s steps, 244us-1s
// - Either alarm may recur at its interval
// - Enabled alarm raises interrupt and wake only when its mask bit is set
// - Interrupt serves as wake source for system
// - Frequency trim of +/-127 ppm, 1 ppm steps
// - Calibration output pin shows RTC timing with dropped ticks, but not inserted ticks
// - Counting continues on backup supply alone
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH
// Register byte offsets
`define RTC_OFS_SEC 8'h00
`define RTC_OFS_SUBSEC 8'h04
`define RTC_OFS_CTRL 8'h08
`define RTC_OFS_TOD_ALM 8'h0C
`define RTC_OFS_SS_ALM 8'h10
`define RTC_OFS_TRIM 8'h14
`define RTC_OFS_INT_STAT 8'h18
`define RTC_OFS_INT_MASK 8'h1C
// Field positions in status and mask
`define RTC_BIT_TOD 0
`define RTC_BIT_SS 1
// Reset values
`define RTC_CTRL_RST 6'h01
`define RTC_MASK_RST 2'h0
// Counts
`define RTC_PRESCALE 3'h7
`define RTC_SUB_BITS 12
`define RTC_TOD_MAX_DAYS 12
`define RTC_SEC_PER_DAY 86400
`define RTC_SS_MAX 4096
`define RTC_TRIM_MAX 127
`define RTC_PPM_SCALE 1000000
`endif

// ==== rtc_pkg.sv ====
// Types shared by the seconds RTC
`default_nettype none
package rtc_pkg;
  // Control register layout
  typedef struct packed {
    logic cal_out_en; // Drive calibration output pin
    logic ss_recur;   // Sub-second alarm reloads after firing
    logic tod_recur;  // Time-of-day alarm reloads after firing
    logic ss_en;      // Sub-second alarm enabled
    logic tod_en;     // Time-of-day alarm enabled
    logic run;        // Counting enabled
  } rtc_ctrl_t;
  // Alarm event flags
  typedef struct packed {
    logic ss;
    logic tod;
  } rtc_evt_t;
endpackage : rtc_pkg
`default_nettype wire

// ==== rtc_seconds.sv ====
// Seconds real-time clock with two alarms, trim and calibration output
`timescale 1ns/1ps
`default_nettype none
`include "rtc_defs.svh"
module rtc_seconds import rtc_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rtc_clk_32k,
  output logic rtc_cal_clock_out,
  output logic rtc_cal_clock_oe,
  output logic irq,
  output logic wake_req
);
  // Every check below runs on the bus clock and sleeps in reset
  default clocking chk_clk @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ------------------------------------------------------------
  // Constants
  // ------------------------------------------------------------
  localparam logic [19:0] TOD_MAX =
    20'(`RTC_TOD_MAX_DAYS * `RTC_SEC_PER_DAY);
  localparam logic [12:0] SS_MAX = 13'(`RTC_SS_MAX);
  localparam logic signed [20:0] PPM = 21'(`RTC_PPM_SCALE);
  localparam logic signed [7:0] TRIM_MAX = 8'(`RTC_TRIM_MAX);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [31:0] sec;            // Absolute seconds
  logic [11:0] sub;            // 1/4096 s fraction
  rtc_ctrl_t ctrl;             // Control bits
  logic [19:0] tod_ivl;        // Time-of-day interval, seconds
  logic [31:0] tod_target;     // Seconds value that fires
  logic tod_armed;             // Target is live
  logic [12:0] ss_ivl;         // Sub-second interval, ticks
  logic [12:0] ss_cnt;         // Ticks left before firing
  logic ss_armed;              // Countdown is live
  logic signed [7:0] trim;     // Signed ppm trim
  logic signed [20:0] acc;     // Trim error accumulator
  rtc_evt_t stat;              // Sticky alarm flags
  rtc_evt_t mask;              // Interrupt enables
  logic [1:0] clk_sync;        // Pin synchroniser
  logic clk_seen;              // Previous synchronised level
  logic [2:0] div;             // Divide-by-eight prescaler

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  // Zero-wait slave; read data is captured in the setup cycle
  wire setup = psel && !penable;
  wire acc_ph = psel && penable;
  wire wr = acc_ph && pwrite;
  wire rd = acc_ph && !pwrite;
  wire hit_sec = paddr == `RTC_OFS_SEC;
  wire hit_sub = paddr == `RTC_OFS_SUBSEC;
  wire hit_ctrl = paddr == `RTC_OFS_CTRL;
  wire hit_tod = paddr == `RTC_OFS_TOD_ALM;
  wire hit_ss = paddr == `RTC_OFS_SS_ALM;
  wire hit_trim = paddr == `RTC_OFS_TRIM;
  wire hit_stat = paddr == `RTC_OFS_INT_STAT;
  wire hit_mask = paddr == `RTC_OFS_INT_MASK;
  wire mapped = hit_sec | hit_sub | hit_ctrl | hit_tod | hit_ss |
                hit_trim | hit_stat | hit_mask;
  assign pready = 1'b1;
  assign pslverr = acc_ph && !mapped;

  // Clamp a requested interval into its legal range
  function automatic logic [19:0] clamp_tod(input logic [31:0] v);
    if (v == 32'h0) begin
      clamp_tod = 20'h00001;
    end else if (v > {12'h0, TOD_MAX}) begin
      clamp_tod = TOD_MAX;
    end else begin
      clamp_tod = v[19:0];
    end
  endfunction : clamp_tod

  // Same for the sub-second interval
  function automatic logic [12:0] clamp_ss(input logic [31:0] v);
    if (v == 32'h0) begin
      clamp_ss = 13'h0001;
    end else if (v > {19'h0, SS_MAX}) begin
      clamp_ss = SS_MAX;
    end else begin
      clamp_ss = v[12:0];
    end
  endfunction : clamp_ss

  wire [7:0] trim_req = pwdata[7:0];
  wire signed [7:0] trim_in =
    ($signed(trim_req) < -TRIM_MAX) ? -TRIM_MAX : $signed(trim_req);

  // ------------------------------------------------------------
  // Timebase
  // ------------------------------------------------------------
  // The outside party supplies 32.768 kHz; it is asynchronous
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_sync <= 2'h0;
      clk_seen <= 1'b0;
    end else begin
      clk_sync <= {clk_sync[0], rtc_clk_32k};
      clk_seen <= clk_sync[1];
    end
  end

  wire edge32 = clk_sync[1] && !clk_seen && ctrl.run;
  wire base_tick = edge32 && (div == `RTC_PRESCALE);

  // Trim: each nominal tick adds trim ppm of a tick to the error;
  // a whole tick of error inserts or swallows one tick
  wire signed [20:0] acc_sum = acc + 21'(trim);
  wire add_tick = base_tick && (acc_sum >= PPM);
  wire drop_tick = base_tick && (acc_sum <= -PPM);
  wire signed [20:0] next_acc = add_tick ? acc_sum - PPM :
                                drop_tick ? acc_sum + PPM : acc_sum;
  wire [1:0] inc = !base_tick ? 2'd0 : add_tick ? 2'd2 :
                   drop_tick ? 2'd0 : 2'd1;

  // Fraction advance and carry into seconds
  wire [12:0] sub_sum = {1'b0, sub} + {11'h0, inc};
  wire sec_tick = sub_sum[12];
  wire [31:0] next_sec = sec + 32'h1;

  // ------------------------------------------------------------
  // Alarm events
  // ------------------------------------------------------------
  // Alarms fire only while enabled
  wire tod_fire = sec_tick && tod_armed && ctrl.tod_en &&
                  (next_sec == tod_target) && !(wr && hit_sec);
  wire ss_fire = (inc != 2'd0) && ss_armed && ctrl.ss_en &&
                 (ss_cnt <= {11'h0, inc});
  wire [12:0] ss_left = ss_cnt - {11'h0, inc};
  rtc_evt_t evt;
  assign evt = '{ss: ss_fire, tod: tod_fire};
  wire stat_clr = rd && hit_stat;
  // Clear only the flags that the read returned in setup
  wire [1:0] clr_bits = stat_clr ? prdata[1:0] : 2'h0;

  // ------------------------------------------------------------
  // Counters, prescaler and trim
  // ------------------------------------------------------------
  // Only presetn (the backup-domain reset) clears time, so the count
  // survives every power mode that keeps the backup supply
  // No calendar conversion here; software reads raw seconds
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= 3'h0;
      acc <= '0;
      sub <= 12'h000;
      sec <= 32'h0;
    end else begin
      if (edge32) begin
        div <= div + 3'h1;
      end
      // Error moves only on a nominal tick, never on every bus cycle
      if (base_tick) begin
        acc <= next_acc;
      end
      if (wr && hit_sub) begin
        sub <= pwdata[11:0];
      end else begin
        sub <= sub_sum[11:0];
      end
      if (wr && hit_sec) begin
        sec <= pwdata;
      end else if (sec_tick) begin
        sec <= next_sec;
      end
    end
  end

  // ------------------------------------------------------------
  // Time-of-day alarm
  // ------------------------------------------------------------
  // Writing the interval arms it relative to the current count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tod_ivl <= 20'h00001;
      tod_target <= 32'h0;
      tod_armed <= 1'b0;
    end else if (wr && hit_tod) begin
      tod_ivl <= clamp_tod(pwdata);
      tod_target <= sec + {12'h0, clamp_tod(pwdata)};
      tod_armed <= 1'b1;
    end else if (tod_fire) begin
      tod_target <= tod_target + {12'h0, tod_ivl};
      tod_armed <= ctrl.tod_recur;
    end
  end

  // ------------------------------------------------------------
  // Sub-second alarm
  // ------------------------------------------------------------
  // A dropped tick never decrements; a doubled one counts as two
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ss_ivl <= 13'h0001;
      ss_cnt <= 13'h0001;
      ss_armed <= 1'b0;
    end else if (wr && hit_ss) begin
      ss_ivl <= clamp_ss(pwdata);
      ss_cnt <= clamp_ss(pwdata);
      ss_armed <= 1'b1;
    end else if (ss_fire) begin
      ss_cnt <= ss_ivl;
      ss_armed <= ctrl.ss_recur;
    end else if (ss_armed && ctrl.ss_en && inc != 2'd0) begin
      ss_cnt <= ss_left;
    end
  end

  // ------------------------------------------------------------
  // Control, trim, mask and status registers
  // ------------------------------------------------------------
  // An alarm in the same cycle as the clearing read stays set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= rtc_ctrl_t'(`RTC_CTRL_RST);
      trim <= 8'sh00;
      mask <= rtc_evt_t'(`RTC_MASK_RST);
      stat <= '0;
    end else begin
      if (wr && hit_ctrl) begin
        ctrl <= rtc_ctrl_t'(pwdata[5:0]);
      end
      if (wr && hit_trim) begin
        trim <= trim_in;
      end
      if (wr && hit_mask) begin
        mask <= rtc_evt_t'(pwdata[1:0]);
      end
      stat <= rtc_evt_t'((stat & ~clr_bits) | evt);
    end
  end

  // ------------------------------------------------------------
  // Read data and outputs
  // ------------------------------------------------------------
  wire [31:0] rd_mux =
    hit_sec ? sec :
    hit_sub ? {20'h0, sub} :
    hit_ctrl ? {26'h0, ctrl} :
    hit_tod ? {12'h0, tod_ivl} :
    hit_ss ? {19'h0, ss_ivl} :
    hit_trim ? {{24{trim[7]}}, trim} :
    hit_stat ? {30'h0, stat} :
    hit_mask ? {30'h0, mask} : 32'h0;

  // Capture read data in setup so prdata comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      irq <= 1'b0;
      rtc_cal_clock_out <= 1'b0;
      rtc_cal_clock_oe <= 1'b0;
    end else begin
      if (setup && !pwrite) begin
        prdata <= rd_mux;
      end
      irq <= |(stat & mask);
      // 4096 Hz tick less dropped ticks, halved: 2048 Hz shows negative trim, not inserted ticks
      if (base_tick && !drop_tick) begin
        rtc_cal_clock_out <= !rtc_cal_clock_out;
      end
      rtc_cal_clock_oe <= ctrl.cal_out_en;
    end
  end

  // Power controller treats the interrupt as a wake source
  assign wake_req = irq;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sec_carry_a: assert property (
    sec_tick && !(wr && hit_sec) |=> sec == $past(sec) + 32'h1)
    else $error("seconds did not advance on fraction wrap");

  sub_wrap_a: assert property (
    sec_tick && !(wr && hit_sub) |=> sub < 12'h002)
    else $error("fraction not wrapped at carry");

  tick_div_a: assert property (
    base_tick |-> div == 3'h7 && edge32)
    else $error("tick not on eighth edge");

  tod_flag_a: assert property (
    tod_fire |=> stat.tod)
    else $error("time-of-day alarm not flagged");

  ss_flag_a: assert property (
    ss_fire && !(wr && hit_ss) |=> stat.ss ##0 ss_cnt == $past(ss_ivl))
    else $error("sub-second alarm not flagged or reloaded");

  flag_hold_a: assert property (
    stat.tod && !stat_clr |=> stat.tod)
    else $error("flag dropped without a clearing read");

  irq_follow_a: assert property (
    (stat.tod && mask.tod) |=> irq ##0 wake_req)
    else $error("enabled flag gave no interrupt");

  one_shot_a: assert property (
    tod_fire && !ctrl.tod_recur && !(wr && hit_tod) |=> !tod_armed)
    else $error("one-shot alarm stayed armed");

  trim_range_a: assert property (
    trim >= -TRIM_MAX && trim <= TRIM_MAX)
    else $error("trim out of range");

  cal_oe_a: assert property (
    !ctrl.cal_out_en |=> !rtc_cal_clock_oe)
    else $error("calibration pin driven while disabled");

  sub_step_a: assert property (
    inc == 2'd1 && !(wr && hit_sub) |=> sub == $past(sub) + 12'h001)
    else $error("fraction did not advance by one tick");

  trim_hold_a: assert property (
    !base_tick |=> acc == $past(acc))
    else $error("trim error moved between ticks");

  flag_keep_a: assert property (
    stat.ss && !(stat_clr && prdata[`RTC_BIT_SS]) |=> stat.ss)
    else $error("unread sub-second flag was lost");
endmodule : rtc_seconds
`default_nettype wire

// ==== rtc_xtal_model.sv ====
// Behavioural model of the 32.768 kHz timebase that feeds the RTC
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Free-running timebase
// ----------------------------------------------------------------
module rtc_xtal_model #(
  parameter int HALF_NS = 15259 // Half period; about 15259 ns for a crystal
) (
  output logic clk_32k
);
  // Square wave that never stops; an oscillator runs free between uses.
  // The bench shortens the period so that the carries and alarms it tests fit in
  // the run, but keeps it well below a quarter of the bus clock rate.
  initial begin
    clk_32k = 1'b0;
    forever #(HALF_NS) clk_32k = ~clk_32k;
  end
endmodule : rtc_xtal_model
`default_nettype wire

// ==== test_rtc_seconds_alarm_calibration.sv ====
// Self-checking bench for the seconds RTC over its register bus
`timescale 1ns/1ps
`default_nettype none
`include "rtc_defs.svh"
module test_rtc_seconds_alarm_calibration import rtc_pkg::*;;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic pclk; // Bus clock, 100 MHz
  logic presetn; // Active-low reset
  logic psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready, pslverr, rtc_clk_32k;
  logic rtc_cal_clock_out, rtc_cal_clock_oe, irq, wake_req;
  int bad_count = 0; // Mismatches seen
  int total_checks = 0; // Comparisons made
  int toggles = 0; // Edges seen on the calibration output
  logic cal_q = 1'b0; // Last sampled calibration output
  logic last_err; // Error flag of the last transfer
  // Bus clock
  always #5 pclk = ~pclk;
  // Fast timebase: 100 ns period keeps a tick at 80 bus cycles
  rtc_xtal_model #(.HALF_NS(50)) i_xtal (.clk_32k(rtc_clk_32k));
  rtc_seconds i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rtc_clk_32k(rtc_clk_32k), .rtc_cal_clock_out(rtc_cal_clock_out),
    .rtc_cal_clock_oe(rtc_cal_clock_oe), .irq(irq), .wake_req(wake_req));
  // Count every change of the calibration output
  always @(posedge pclk) begin
    cal_q <= rtc_cal_clock_out;
    if (rtc_cal_clock_out !== cal_q) toggles++;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Setup then access; holds everything until pready is sampled high
  task apb_xfer(input logic [7:0] a, input logic wr, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb_xfer
  task apb_wr(input logic [7:0] a, input logic [31:0] d);
    apb_xfer(a, 1'b1, d);
  endtask : apb_wr
  // Read; compares only when asked, since some reads just clear flags
  task apb_rd(input logic [7:0] a, input logic [31:0] exp, input bit c);
    apb_xfer(a, 1'b0, 32'h0);
    if (c) chk(prdata, exp);
  endtask : apb_rd
  // Bounded wait for the interrupt line
  task wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, irq}, 32'h1);
  endtask : wait_irq
  task wrap_up;
    if (bad_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up
  // Watchdog: the tests need about 5000 cycles
  initial begin
    #200000;
    bad_count++;
    wrap_up();
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values
    apb_rd(`RTC_OFS_SEC, 32'h0, 1);
    apb_rd(`RTC_OFS_CTRL, 32'h1, 1);
    apb_rd(`RTC_OFS_TOD_ALM, 32'h1, 1);
    apb_rd(`RTC_OFS_SS_ALM, 32'h1, 1);
    apb_rd(`RTC_OFS_TRIM, 32'h0, 1);
    apb_rd(`RTC_OFS_INT_STAT, 32'h0, 1);
    apb_rd(`RTC_OFS_INT_MASK, 32'h0, 1);
    // Unmapped place answers with an error and zero data
    apb_rd(8'h20, 32'h0, 1);
    chk({31'h0, last_err}, 32'h1);
    // Stopped counter holds; then the sub-second wrap carries and the
    // 32-bit seconds count rolls over to zero
    apb_wr(`RTC_OFS_CTRL, 32'h0);
    apb_wr(`RTC_OFS_SEC, 32'hFFFFFFFF);
    apb_wr(`RTC_OFS_SUBSEC, 32'hFFE);
    repeat (200) @(posedge pclk);
    apb_rd(`RTC_OFS_SUBSEC, 32'hFFE, 1);
    apb_wr(`RTC_OFS_CTRL, 32'h1);
    repeat (400) @(posedge pclk);
    apb_rd(`RTC_OFS_SEC, 32'h0, 1);
    // One-shot sub-second alarm, masked: flag sticks, line stays low
    apb_wr(`RTC_OFS_CTRL, 32'h05);
    apb_wr(`RTC_OFS_SS_ALM, 32'h3);
    repeat (500) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb_rd(`RTC_OFS_INT_STAT, 32'h2, 1);
    apb_rd(`RTC_OFS_INT_STAT, 32'h0, 1);
    // Recurring sub-second alarm, unmasked
    apb_wr(`RTC_OFS_INT_MASK, 32'h2);
    apb_wr(`RTC_OFS_CTRL, 32'h15);
    apb_wr(`RTC_OFS_SS_ALM, 32'h3);
    wait_irq();
    chk({31'h0, wake_req}, 32'h1);
    apb_rd(`RTC_OFS_INT_STAT, 32'h2, 1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    wait_irq();
    apb_rd(`RTC_OFS_INT_STAT, 32'h2, 1);
    // Time-of-day alarm one second ahead fires at the carry
    apb_wr(`RTC_OFS_CTRL, 32'h0);
    apb_wr(`RTC_OFS_SEC, 32'd100);
    apb_wr(`RTC_OFS_SUBSEC, 32'hFFA);
    apb_wr(`RTC_OFS_TOD_ALM, 32'h1);
    apb_rd(`RTC_OFS_INT_STAT, 32'h0, 0);
    apb_wr(`RTC_OFS_INT_MASK, 32'h1);
    apb_wr(`RTC_OFS_CTRL, 32'h03);
    wait_irq();
    apb_rd(`RTC_OFS_INT_STAT, 32'h1, 1);
    apb_rd(`RTC_OFS_SEC, 32'd101, 1);
    // One-shot stays quiet at the next carry; recurring fires twice
    apb_wr(`RTC_OFS_SUBSEC, 32'hFFA);
    repeat (600) @(posedge pclk);
    apb_rd(`RTC_OFS_INT_STAT, 32'h0, 1);
    apb_wr(`RTC_OFS_CTRL, 32'h0B);
    apb_wr(`RTC_OFS_TOD_ALM, 32'h1);
    apb_wr(`RTC_OFS_SUBSEC, 32'hFFA);
    wait_irq();
    apb_rd(`RTC_OFS_INT_STAT, 32'h1, 1);
    apb_wr(`RTC_OFS_SUBSEC, 32'hFFA);
    wait_irq();
    apb_rd(`RTC_OFS_INT_STAT, 32'h1, 1);
    apb_rd(`RTC_OFS_SEC, 32'd104, 1);
    // Interval limits: 12 days and 4096 sub-ticks at most, one at least
    apb_wr(`RTC_OFS_TOD_ALM, 32'hFFFFFFFF);
    apb_rd(`RTC_OFS_TOD_ALM, 32'h000FD200, 1);
    apb_wr(`RTC_OFS_TOD_ALM, 32'h0);
    apb_rd(`RTC_OFS_TOD_ALM, 32'h1, 1);
    apb_wr(`RTC_OFS_SS_ALM, 32'h10000000);
    apb_rd(`RTC_OFS_SS_ALM, 32'h1000, 1);
    apb_wr(`RTC_OFS_SS_ALM, 32'h0);
    apb_rd(`RTC_OFS_SS_ALM, 32'h1, 1);
    // Trim limits of plus and minus 127
    apb_wr(`RTC_OFS_TRIM, 32'h80);
    apb_rd(`RTC_OFS_TRIM, 32'hFFFFFF81, 1);
    apb_wr(`RTC_OFS_TRIM, 32'h7F);
    apb_rd(`RTC_OFS_TRIM, 32'h7F, 1);
    // Calibration output: one edge per tick, about ten in 800 cycles
    apb_wr(`RTC_OFS_CTRL, 32'h21);
    repeat (3) @(posedge pclk);
    chk({31'h0, rtc_cal_clock_oe}, 32'h1);
    toggles = 0;
    repeat (800) @(posedge pclk);
    chk({31'h0, toggles >= 8 && toggles <= 12}, 32'h1);
    apb_wr(`RTC_OFS_CTRL, 32'h1);
    repeat (3) @(posedge pclk);
    chk({31'h0, rtc_cal_clock_oe}, 32'h0);
    wrap_up();
  end
endmodule : test_rtc_seconds_alarm_calibration
`default_nettype wire
